// File: dlic_pkg.sv
// shared constants, register map and bus carriers of the interrupt controller
package dlic_pkg;

	// ------------------------------------------------------------
	// source map
	// ------------------------------------------------------------
	localparam int          N_SRC      = 32;
	localparam int          SRC_FAST   = 0;             // fast-level OR
	localparam int          SRC_SWI    = 1;             // programmed source
	localparam logic [31:0] SRC_PERIPH = 32'h000F_7FFC; // 2..14, 16..19
	localparam logic [31:0] EN_MASK_N  = 32'h000F_7FFD; // peripherals, bit 0
	localparam logic [31:0] EN_MASK_F  = 32'h000F_7FFC; // peripherals only
	localparam int          SWI_BIT_N  = 1;
	localparam int          SWI_BIT_F  = 2;
	localparam logic [31:0] SWI_MASK   = 32'h0000_0006;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] A_N_STAT   = 32'hFFFF_0000;
	localparam logic [31:0] A_N_RAW    = 32'hFFFF_0004;
	localparam logic [31:0] A_N_EN     = 32'hFFFF_0008;
	localparam logic [31:0] A_N_CLR    = 32'hFFFF_000C;
	localparam logic [31:0] A_SWI      = 32'hFFFF_0010;
	localparam logic [31:0] A_F_STAT   = 32'hFFFF_0100;
	localparam logic [31:0] A_F_RAW    = 32'hFFFF_0104;
	localparam logic [31:0] A_F_EN     = 32'hFFFF_0108;
	localparam logic [31:0] A_F_CLR    = 32'hFFFF_010C;
	localparam logic [31:0] A_EV_STAT  = 32'hFFFF_0200;
	localparam logic [31:0] A_EV_MASK  = 32'hFFFF_0204;

	// ------------------------------------------------------------
	// reset values and event bits
	// ------------------------------------------------------------
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam int          N_EV       = 3;
	localparam int          EV_NRISE   = 0;  // normal request rose
	localparam int          EV_FRISE   = 1;  // fast request rose
	localparam int          EV_BUSERR  = 2;  // unmapped access

	// ------------------------------------------------------------
	// bus carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_s;

endpackage

// File: dlic_level.sv
// enable mask of one interrupt level, set-only and clear-only writes
`timescale 1ns/100ps
module dlic_level #(
	parameter int          W    = 32,
	parameter logic [31:0] MASK = 32'h0000_0000
) (
	input  wire logic         clk_sys, // core clock
	input  wire logic         srst,    // sync reset, high
	input  wire logic         set_we,  // write to this enable mask
	input  wire logic         clr_we,  // write to this mask-clear
	input  wire logic         xset_we, // write to other level's enable
	input  wire logic [W-1:0] wdata,   // bus write data
	output logic      [W-1:0] en_q     // current enable mask
);

	logic [W-1:0] en_d;

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (W < 1 || W > 32)
		$error("dlic_level: width out of range");

	// ------------------------------------------------------------
	// per-bit next value
	// ------------------------------------------------------------
	// a set from this level wins; only one bus write per cycle anyway
	for (genvar i = 0; i < W; i++)
	begin : g_bit
		always_comb
		begin
			en_d[i] = en_q[i];
			if (!MASK[i])
				en_d[i] = 1'b0;
			else if (set_we && wdata[i])
				en_d[i] = 1'b1;
			else if (clr_we && wdata[i])
				en_d[i] = 1'b0;
			else if (xset_we && wdata[i])
				en_d[i] = 1'b0;
		end
	end

	// register stage
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			en_q <= dlic_pkg::RST_WORD[W-1:0];
		else
			en_q <= en_d;
	end

endmodule

// File: dlic_events.sv
// sticky event status, mask and level interrupt output
`timescale 1ns/100ps
module dlic_events #(
	parameter int N = 3
) (
	input  wire logic         clk_sys, // core clock
	input  wire logic         srst,    // sync reset, high
	input  wire logic [N-1:0] ev,      // one-cycle event pulses
	input  wire logic         rd_clr,  // status read in its setup cycle
	input  wire logic         mask_we, // mask register write
	input  wire logic [N-1:0] wdata,   // bus write data
	output logic      [N-1:0] sts_q,   // sticky status
	output logic      [N-1:0] msk_q,   // interrupt mask
	output logic              irq_q    // level interrupt
);

	logic [N-1:0] sts_d;
	logic [N-1:0] msk_d;
	logic         irq_d;

	if (N < 1 || N > 32)
		$error("dlic_events: event count out of range");

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// an event in the read-clear cycle survives the clear
	always_comb
	begin
		sts_d = rd_clr ? ev : (sts_q | ev);
		msk_d = mask_we ? wdata : msk_q;
		irq_d = |(sts_d & msk_d);
	end

	// register stage
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			sts_q <= '0;
			msk_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			sts_q <= sts_d;
			msk_q <= msk_d;
			irq_q <= irq_d;
		end
	end

endmodule

// File: dlic_top.sv
// dual-level interrupt controller with apb register access
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
module dlic_top #(
	parameter int N_SRC = dlic_pkg::N_SRC
) (
	input  wire logic               clk_sys,  // core clock, 200 MHz
	input  wire logic               srst,     // sync reset, high
	input  wire dlic_pkg::apb_req_s apb_req,  // apb request
	output dlic_pkg::apb_rsp_s      apb_rsp,  // apb response
	input  wire logic [N_SRC-1:0]   src_irq,  // peripheral requests
	output logic                    irq_req,  // normal request to core
	output logic                    fiq_req,  // fast request to core
	output logic                    evt_irq   // controller event interrupt
);

	logic [31:0] nraw;
	logic [31:0] fraw;
	logic [31:0] nstat;
	logic [31:0] fstat;
	logic [31:0] nen_q;
	logic [31:0] fen_q;
	logic [31:0] periph;
	logic        fast_or;
	logic [2:0]  swi_q;
	logic [2:0]  swi_d;
	logic        irq_d;
	logic        fiq_d;
	logic        setup;
	logic        wr_done;
	logic        rd_done;
	logic [31:0] rd_mux;
	logic        hit;
	dlic_pkg::apb_rsp_s rsp_d;
	logic [dlic_pkg::N_EV-1:0] ev;
	logic [dlic_pkg::N_EV-1:0] ev_sts;
	logic [dlic_pkg::N_EV-1:0] ev_msk;
	logic        err_q;
	logic        err_d;

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (N_SRC != 32)
		$error("dlic_top: the source map needs exactly 32 sources");

	// ------------------------------------------------------------
	// bus phase decode
	// ------------------------------------------------------------
	// no wait state: the answer is built in setup, writes take effect
	// only at the completing access edge
	assign setup   = apb_req.psel && !apb_req.penable;
	assign wr_done = apb_req.psel && apb_req.penable && apb_rsp.pready
		&& apb_req.pwrite;
	// an event status read clears at its setup edge, the very cycle whose value
	// it returns, so an event raised in the setup cycle is not lost
	assign rd_done = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

	// ------------------------------------------------------------
	// source combination
	// ------------------------------------------------------------
	// fast bit 0 is itself the OR, so it is kept out of its own OR
	always_comb
	begin
		periph  = src_irq & dlic_pkg::SRC_PERIPH;
		fstat   = periph & fen_q;
		fstat[dlic_pkg::SRC_SWI] = swi_q[dlic_pkg::SWI_BIT_F];
		fast_or = |fstat[31:1];
		fstat[dlic_pkg::SRC_FAST] = fast_or;
		fraw    = periph;
		fraw[dlic_pkg::SRC_SWI]  = swi_q[dlic_pkg::SWI_BIT_F];
		fraw[dlic_pkg::SRC_FAST] = fast_or;
		nraw    = periph;
		nraw[dlic_pkg::SRC_SWI]  = swi_q[dlic_pkg::SWI_BIT_N];
		nraw[dlic_pkg::SRC_FAST] = fast_or;
		nstat   = nraw & nen_q;
		nstat[dlic_pkg::SRC_SWI] = swi_q[dlic_pkg::SWI_BIT_N];
		irq_d   = |nstat;
		fiq_d   = |fstat;
	end

	// ------------------------------------------------------------
	// enable masks of both levels
	// ------------------------------------------------------------
	dlic_level #(
		.W    (32),
		.MASK (dlic_pkg::EN_MASK_N)
	) u_normal (
		.clk_sys (clk_sys),
		.srst    (srst),
		.set_we  (wr_done && apb_req.paddr == dlic_pkg::A_N_EN),
		.clr_we  (wr_done && apb_req.paddr == dlic_pkg::A_N_CLR),
		.xset_we (wr_done && apb_req.paddr == dlic_pkg::A_F_EN),
		.wdata   (apb_req.pwdata),
		.en_q    (nen_q)
	);

	// second level, same structure
	dlic_level #(
		.W    (32),
		.MASK (dlic_pkg::EN_MASK_F)
	) u_fast (
		.clk_sys (clk_sys),
		.srst    (srst),
		.set_we  (wr_done && apb_req.paddr == dlic_pkg::A_F_EN),
		.clr_we  (wr_done && apb_req.paddr == dlic_pkg::A_F_CLR),
		.xset_we (wr_done && apb_req.paddr == dlic_pkg::A_N_EN),
		.wdata   (apb_req.pwdata),
		.en_q    (fen_q)
	);

	// ------------------------------------------------------------
	// programmed interrupt, request outputs
	// ------------------------------------------------------------
	// reserved bits 0 and 3 up are never stored
	always_comb
	begin
		swi_d = swi_q;
		if (wr_done && apb_req.paddr == dlic_pkg::A_SWI)
			swi_d = apb_req.pwdata[2:0] & dlic_pkg::SWI_MASK[2:0];
	end

	// requests are registered, one cycle behind the status
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			swi_q   <= 3'h0;
			irq_req <= 1'b0;
			fiq_req <= 1'b0;
		end
		else
		begin
			swi_q   <= swi_d;
			irq_req <= irq_d;
			fiq_req <= fiq_d;
		end
	end

	// ------------------------------------------------------------
	// read mux and slave answer
	// ------------------------------------------------------------
	// plain status words, no vector: software scans the bits
	always_comb
	begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (apb_req.paddr)
			dlic_pkg::A_N_STAT:  rd_mux = nstat;
			dlic_pkg::A_N_RAW:   rd_mux = nraw;
			dlic_pkg::A_N_EN:    rd_mux = nen_q;
			dlic_pkg::A_N_CLR:   rd_mux = 32'h0000_0000;   // write only
			dlic_pkg::A_SWI:     rd_mux = {29'h0000_0000, swi_q};
			dlic_pkg::A_F_STAT:  rd_mux = fstat;
			dlic_pkg::A_F_RAW:   rd_mux = fraw;
			dlic_pkg::A_F_EN:    rd_mux = fen_q;
			dlic_pkg::A_F_CLR:   rd_mux = 32'h0000_0000;
			dlic_pkg::A_EV_STAT: rd_mux = {29'h0000_0000, ev_sts};
			dlic_pkg::A_EV_MASK: rd_mux = {29'h0000_0000, ev_msk};
			default:             hit = 1'b0;
		endcase
		rsp_d.pready  = setup;
		rsp_d.pslverr = setup && !hit;
		rsp_d.prdata  = (setup && !apb_req.pwrite) ? rd_mux : 32'h0000_0000;
		err_d         = setup && !hit;
	end

	// response register
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			apb_rsp <= '0;
			err_q   <= 1'b0;
		end
		else
		begin
			apb_rsp <= rsp_d;
			err_q   <= err_d;
		end
	end

	// ------------------------------------------------------------
	// controller events
	// ------------------------------------------------------------
	// rising requests and bus errors, for a supervisor that polls less
	always_comb
	begin
		ev = '0;
		ev[dlic_pkg::EV_NRISE]  = irq_d && !irq_req;
		ev[dlic_pkg::EV_FRISE]  = fiq_d && !fiq_req;
		ev[dlic_pkg::EV_BUSERR] = err_q;
	end

	dlic_events #(
		.N (dlic_pkg::N_EV)
	) u_events (
		.clk_sys (clk_sys),
		.srst    (srst),
		.ev      (ev),
		.rd_clr  (rd_done && apb_req.paddr == dlic_pkg::A_EV_STAT),
		.mask_we (wr_done && apb_req.paddr == dlic_pkg::A_EV_MASK),
		.wdata   (apb_req.pwdata[dlic_pkg::N_EV-1:0]),
		.sts_q   (ev_sts),
		.msk_q   (ev_msk),
		.irq_q   (evt_irq)
	);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence s_en_write;
		wr_done && apb_req.paddr == dlic_pkg::A_N_EN;
	endsequence

	sequence s_clr_write;
		wr_done && apb_req.paddr == dlic_pkg::A_N_CLR;
	endsequence

	sequence s_fen_write;
		wr_done && apb_req.paddr == dlic_pkg::A_F_EN;
	endsequence

	sequence s_fclr_write;
		wr_done && apb_req.paddr == dlic_pkg::A_F_CLR;
	endsequence

	// an unmapped setup: error answer next, event bit one edge later
	sequence s_bad_setup;
		setup && !hit;
	endsequence

	a_irq_or_out: assert property (irq_d |=> irq_req)
		else $error("normal request missing after status bit");
	a_stat_masked: assert property (
		(nstat & ~nen_q & ~32'h0000_0002) == 32'h0000_0000)
		else $error("normal status bit set without enable");
	a_raw_follow: assert property (
		nraw[31:2] == (src_irq[31:2] & dlic_pkg::SRC_PERIPH[31:2]))
		else $error("raw register does not follow sources");
	a_set_only: assert property (s_en_write |=>
		((nen_q & ($past(apb_req.pwdata) & dlic_pkg::EN_MASK_N))
		== ($past(apb_req.pwdata) & dlic_pkg::EN_MASK_N))
		&& ((nen_q & $past(nen_q)) == $past(nen_q)))
		else $error("enable write lost or cleared bits");
	a_clr_bits: assert property (s_clr_write |=>
		((nen_q & $past(apb_req.pwdata)) == 32'h0000_0000)
		&& (nen_q == ($past(nen_q) & ~$past(apb_req.pwdata))))
		else $error("mask clear did not act bitwise");
	a_fiq_bit0: assert property (fiq_d |=> fiq_req
		&& $past(nraw[0]) && $past(fraw[0]))
		else $error("fast OR not on bit 0 of both levels");
	a_excl_enable: assert property ((nen_q & fen_q) == 32'h0000_0000)
		else $error("source enabled on both levels");
	a_swi_bypass: assert property (
		swi_q[1] |-> nstat[1] && nraw[1] ##1 irq_req)
		else $error("programmed interrupt not on normal level");
	a_resv_zero: assert property (((nraw | fraw | nstat | fstat)
		& 32'hFFF0_8000) == 32'h0000_0000)
		else $error("reserved source position asserted");
	a_apb_ready: assert property (setup |=> apb_rsp.pready ##1
		!apb_rsp.pready)
		else $error("slave answer not one cycle after setup");

	// both levels may carry a programmed request at the same time
	a_swi_fast: assert property (
		swi_q[2] |-> fstat[1] && fraw[1] ##1 fiq_req)
		else $error("programmed interrupt not on fast level");
	a_swi_resv: assert property (swi_q[0] == 1'b0)
		else $error("reserved software config bit stored");
	a_irq_low: assert property (!irq_d |=> !irq_req)
		else $error("normal request without status bit");
	a_fiq_low: assert property (!fiq_d |=> !fiq_req)
		else $error("fast request without status bit");
	a_fen_set: assert property (
		s_fen_write |=> (((dlic_pkg::EN_MASK_F & ~fen_q)
		& $past(apb_req.pwdata)) == 32'h0000_0000)
		&& (($past(fen_q) & ~fen_q) == 32'h0000_0000))
		else $error("fast enable write lost or cleared bits");
	a_fclr_bits: assert property (
		s_fclr_write |=> fen_q
		== ($past(fen_q) & ~$past(apb_req.pwdata)))
		else $error("fast mask clear did not act bitwise");
	a_fen_xclr: assert property (
		s_fen_write |=> (nen_q & $past(apb_req.pwdata))
		== 32'h0000_0000)
		else $error("fast enable did not clear normal enable");
	a_en_xclr: assert property (
		s_en_write |=> (fen_q & $past(apb_req.pwdata))
		== 32'h0000_0000)
		else $error("normal enable did not clear fast enable");
	a_err_resp: assert property (s_bad_setup |=> apb_rsp.pready
		&& apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	a_err_event: assert property (
		s_bad_setup |-> ##2 ev_sts[dlic_pkg::EV_BUSERR])
		else $error("bus error event not recorded");

endmodule

// File: dlic_periph_model.sv
// peripheral request model: raises at once, drops only after a hold time
`timescale 1ns/100ps
module dlic_periph_model #(
	parameter int MIN_HOLD = 4
) (
	input  wire logic        clk_sys, // core clock
	input  wire logic        srst,    // sync reset, high
	input  wire logic [31:0] want,    // requests asked by the bench
	output logic      [31:0] src_irq  // requests seen by the controller
);
	logic [31:0] nxt;
	logic [31:0] src_q;
	int          age_q;

	// --------------------------------------------------------
	// request hold
	// --------------------------------------------------------
	// a drop waits until the request has stood long enough
	assign nxt = (age_q >= MIN_HOLD) ? want : (src_q | want);
	assign src_irq = src_q;

	// age restarts whenever the request vector moves
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			src_q <= 32'h0000_0000;
			age_q <= 0;
		end
		else
		begin
			src_q <= nxt;
			age_q <= (nxt != src_q) ? 0 : age_q + int'(age_q < MIN_HOLD);
		end
	end
endmodule

// File: dual_level_interrupt_controller_tb.sv
// self-checking bench for the dual-level interrupt controller
`timescale 1ns/100ps
module dual_level_interrupt_controller_tb;
	logic               clk_sys;
	logic               srst;
	dlic_pkg::apb_req_s apb_req;
	dlic_pkg::apb_rsp_s apb_rsp;
	logic [31:0]        want;
	logic [31:0]        src_irq;
	logic               irq_req;
	logic               fiq_req;
	logic               evt_irq;
	logic [31:0]        rd;
	logic               err;
	int                 bad_count;
	int                 checked;
	logic [31:0]        regs [10];

	// --------------------------------------------------------
	// clock, design and peripheral model
	// --------------------------------------------------------
	initial clk_sys = 1'b0;
	always #2.5 clk_sys = ~clk_sys;

	dlic_top dut (
		.clk_sys (clk_sys),
		.srst    (srst),
		.apb_req (apb_req),
		.apb_rsp (apb_rsp),
		.src_irq (src_irq),
		.irq_req (irq_req),
		.fiq_req (fiq_req),
		.evt_irq (evt_irq)
	);

	dlic_periph_model periph (
		.clk_sys (clk_sys),
		.srst    (srst),
		.want    (want),
		.src_irq (src_irq)
	);

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one transfer; waits on pready, no latency assumed
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		// pready is looked at on the rising edge that completes the access
		do
			@(posedge clk_sys);
		while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// enough for the model hold time and the registered outputs
	task automatic settle();
		repeat (8) @(posedge clk_sys);
	endtask

	task automatic summarize();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// --------------------------------------------------------
	// tests
	// --------------------------------------------------------
	initial
	begin
		bad_count = 0;
		checked = 0;
		srst = 1'b1;
		want = 32'h0000_0000;
		apb_req = '0;
		regs = '{dlic_pkg::A_N_STAT, dlic_pkg::A_N_RAW, dlic_pkg::A_N_EN,
			dlic_pkg::A_N_CLR, dlic_pkg::A_SWI, dlic_pkg::A_F_STAT,
			dlic_pkg::A_F_RAW, dlic_pkg::A_F_EN, dlic_pkg::A_EV_STAT,
			dlic_pkg::A_EV_MASK};
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		foreach (regs[i])
			rchk(regs[i], 32'h0000_0000);
		$display("test reset done");
		// bit 15 is reserved and must not show
		want <= 32'h0008_8004;
		settle();
		rchk(dlic_pkg::A_N_RAW, 32'h0008_0004);
		rchk(dlic_pkg::A_F_RAW, 32'h0008_0004);
		rchk(dlic_pkg::A_N_STAT, 32'h0000_0000);
		$display("test raw done");
		apb(1'b1, dlic_pkg::A_N_EN, 32'h0000_8004);
		apb(1'b1, dlic_pkg::A_N_EN, 32'h0000_0000);
		rchk(dlic_pkg::A_N_EN, 32'h0000_0004);
		rchk(dlic_pkg::A_N_STAT, 32'h0000_0004);
		chk(irq_req, 32'h1);
		$display("test normal enable done");
		apb(1'b1, dlic_pkg::A_F_EN, 32'h0008_0004);
		rchk(dlic_pkg::A_N_EN, 32'h0000_0000);
		rchk(dlic_pkg::A_F_STAT, 32'h0008_0005);
		rchk(dlic_pkg::A_N_RAW, 32'h0008_0005);
		chk(irq_req, 32'h0);
		chk(fiq_req, 32'h1);
		apb(1'b1, dlic_pkg::A_N_EN, 32'h0000_0001);
		rchk(dlic_pkg::A_N_STAT, 32'h0000_0001);
		chk(irq_req, 32'h1);
		apb(1'b1, dlic_pkg::A_F_CLR, 32'h0000_0004);
		rchk(dlic_pkg::A_F_EN, 32'h0008_0000);
		rchk(dlic_pkg::A_N_EN, 32'h0000_0001);
		want <= 32'h0000_0000;
		settle();
		rchk(dlic_pkg::A_F_RAW, 32'h0000_0000);
		chk(fiq_req, 32'h0);
		chk(irq_req, 32'h0);
		$display("test fast level done");
		// reserved config bits are dropped
		apb(1'b1, dlic_pkg::A_SWI, 32'hFFFF_FFFF);
		rchk(dlic_pkg::A_SWI, 32'h0000_0006);
		rchk(dlic_pkg::A_N_STAT, 32'h0000_0003);
		rchk(dlic_pkg::A_F_STAT, 32'h0000_0003);
		apb(1'b1, dlic_pkg::A_SWI, 32'h0000_0002);
		rchk(dlic_pkg::A_F_RAW, 32'h0000_0000);
		rchk(dlic_pkg::A_N_RAW, 32'h0000_0002);
		chk(irq_req, 32'h1);
		apb(1'b1, dlic_pkg::A_SWI, 32'h0000_0004);
		rchk(dlic_pkg::A_N_STAT, 32'h0000_0001);
		chk(fiq_req, 32'h1);
		apb(1'b1, dlic_pkg::A_SWI, 32'h0000_0000);
		$display("test software done");
		// only the bus error is unmasked
		apb(1'b1, dlic_pkg::A_EV_MASK, 32'h0000_0004);
		rchk(dlic_pkg::A_EV_STAT, 32'h0000_0003);
		chk(evt_irq, 32'h0);
		apb(1'b0, 32'hFFFF_0014, 32'h0000_0000);
		chk(err, 32'h1);
		chk(rd, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		chk(evt_irq, 32'h1);
		rchk(dlic_pkg::A_EV_STAT, 32'h0000_0004);
		repeat (2) @(posedge clk_sys);
		chk(evt_irq, 32'h0);
		$display("test events done");
		// a one-cycle request still stands for the model hold time
		want <= 32'h0000_0008;
		@(posedge clk_sys);
		want <= 32'h0000_0000;
		rchk(dlic_pkg::A_N_RAW, 32'h0000_0008);
		settle();
		rchk(dlic_pkg::A_N_RAW, 32'h0000_0000);
		$display("test hold done");
		summarize();
	end

	// hang guard, far beyond the 160 or so cycles used
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		summarize();
	end
endmodule
